// file: pkg/pa_loop_pkg.sv
/*
  Shared constants and types for the power-amplifier loop configuration block.
  Assumes a 50 MHz system clock and a serial register port with 16-bit registers.
*/
// What this block does
// - Each of bits 11 to 0 of the background enable register turns on background conversion of one monitored quantity.
// - Bits 11 to 8 of the loop control register turn on the soft integrator limit of channels 3 to 0.
// - Bits 3 to 0 of the loop control register turn on the closed current loop of channels 3 to 0.
// - Bit 9 of the amplifier control register drives the amplifier power output on or off, off at reset.
// - With bit 8 set, its reset value, a supply alarm or the first alert output turns the output off.
// - With bit 5 set, its reset value, the output snoozes after the second sleep pin acts.
// - With bit 4 set, its reset value, the output snoozes after the first sleep pin acts.
// - With bit 1 set the second sleep pin controls the output; clear at reset.
// - With bit 0 set the first sleep pin controls the output; clear at reset.
// - Four consecutive ramp time registers hold a 7-bit ramp code in bits 6 to 0.
// - A ramp code of zero, the reset value, disables ramping.
// - Ramp codes 1 to 16 all give the minimum ramp time of 4 ms.
// - Bit 15 of the fast-ramp register enables fast ramp of loop 3 and is set at reset.
// - Bits 14 to 12 select the loop 3 integrator time constant, code 3 at reset, code 0 not applicable.
package pa_loop_pkg;

    localparam int CLK_MHZ = 50;
    localparam logic [6:0] ADDR_BG = 7'h23;
    localparam logic [6:0] ADDR_LOOP = 7'h28;
    localparam logic [6:0] ADDR_PA = 7'h29;
    localparam logic [6:0] ADDR_RAMP0 = 7'h2A;
    localparam logic [6:0] ADDR_RAMP3 = 7'h2D;
    localparam logic [6:0] ADDR_FRTC = 7'h2E;
    localparam logic [15:0] MASK_BG = 16'h0FFF;
    localparam logic [15:0] MASK_LOOP = 16'h0F0F;
    localparam logic [15:0] MASK_PA = 16'h0333;
    localparam logic [15:0] MASK_RAMP = 16'h007F;
    localparam logic [15:0] MASK_FRTC = 16'hF000;
    localparam logic [15:0] RST_BG = 16'h0000;
    localparam logic [15:0] RST_LOOP = 16'h0000;
    localparam logic [15:0] RST_PA = 16'h0130;
    localparam logic [15:0] RST_RAMP = 16'h0000;
    localparam logic [15:0] RST_FRTC = 16'hB000;
    localparam int PA_EN_BIT = 9;
    localparam int PA_TRIG_BIT = 8;
    localparam int PA_SNZ_B_BIT = 5;
    localparam int PA_SNZ_A_BIT = 4;
    localparam int PA_SLP_B_BIT = 1;
    localparam int PA_SLP_A_BIT = 0;
    localparam int LIMIT_LSB = 8;
    localparam int LOOP_LSB = 0;
    localparam int FR3_BIT = 15;
    localparam int TC3_LSB = 12;
    localparam logic [2:0] TC_NOT_APPLICABLE = 3'h0;
    localparam int RAMP_MIN_US = 4000;
    localparam int RAMP_STEP_US = 250;
    localparam logic [6:0] RAMP_MIN_CODE = 7'(RAMP_MIN_US / RAMP_STEP_US);
    localparam int RAMP_STEP_CYCLES = RAMP_STEP_US * CLK_MHZ;
    localparam logic [4:0] CMD_LAST = 5'h07;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam int READ_BIT = 7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } spi_pins_t;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_CMD = 2'b01,
        SPI_DATA = 2'b11
    } spi_state_t;

    function automatic logic [6:0] ramp_quarters(input logic [6:0] code);
        if (code == 7'h00) begin
            ramp_quarters = 7'h00;
        end else if (code <= RAMP_MIN_CODE) begin
            ramp_quarters = RAMP_MIN_CODE;
        end else begin
            ramp_quarters = code;
        end
    endfunction

endpackage

// file: hdl/pin_sync.sv
/*
  Two-stage synchroniser for a group of asynchronous pin levels.
  Assumes the inputs are levels that stay stable for several clock cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: hdl/spi_reg_port.sv
/*
  Serial register port: an 8-bit command (read flag and 7-bit address) then 16 data bits, MSB first.
  Assumes the serial clock idles low and runs at most one eighth of the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module spi_reg_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic [15:0] rdata_i,
    output var pa_loop_pkg::reg_req_t req_o,
    output logic miso_o,
    output logic miso_oe_o
);
    pa_loop_pkg::spi_pins_t pins_s;
    pa_loop_pkg::spi_state_t state_q;
    logic sclk_q;
    logic [4:0] cnt_q;
    logic [15:0] shift_q;
    logic [15:0] tx_q;
    logic read_q;

    // Chip select resets to its idle (deselected) level so no false frame follows reset.
    pin_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({sclk_i, cs_n_i, mosi_i}),
        .q_o(pins_s)
    );

    // --------------------------------------------------------------
    // Edge detection and frame sequencing.
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= pins_s.sclk;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= pa_loop_pkg::SPI_IDLE;
            cnt_q <= 5'h00;
            shift_q <= 16'h0000;
            tx_q <= 16'h0000;
            read_q <= 1'b0;
            req_o <= '0;
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            req_o.wr <= 1'b0;
            req_o.rd <= 1'b0;
            if (req_o.rd) begin
                tx_q <= rdata_i;
            end
            if (pins_s.cs_n) begin
                state_q <= pa_loop_pkg::SPI_IDLE;
                cnt_q <= 5'h00;
                miso_oe_o <= 1'b0;
                miso_o <= 1'b0;
            end else begin
                unique case (state_q)
                    pa_loop_pkg::SPI_IDLE: begin
                        state_q <= pa_loop_pkg::SPI_CMD;
                        miso_oe_o <= 1'b1;
                    end
                    pa_loop_pkg::SPI_CMD: begin
                        if (pins_s.sclk && !sclk_q) begin
                            shift_q <= {shift_q[14:0], pins_s.mosi};
                            cnt_q <= cnt_q + 5'h01;
                            if (cnt_q == pa_loop_pkg::CMD_LAST) begin
                                state_q <= pa_loop_pkg::SPI_DATA;
                                cnt_q <= 5'h00;
                                read_q <= shift_q[pa_loop_pkg::READ_BIT - 1];
                                req_o.addr <= {shift_q[5:0], pins_s.mosi};
                                req_o.rd <= shift_q[pa_loop_pkg::READ_BIT - 1];
                            end
                        end
                    end
                    pa_loop_pkg::SPI_DATA: begin
                        if (pins_s.sclk && !sclk_q) begin
                            shift_q <= {shift_q[14:0], pins_s.mosi};
                            if (cnt_q <= pa_loop_pkg::DATA_LAST) begin
                                cnt_q <= cnt_q + 5'h01;
                            end
                            if (cnt_q == pa_loop_pkg::DATA_LAST && !read_q) begin
                                req_o.wr <= 1'b1;
                                req_o.wdata <= {shift_q[14:0], pins_s.mosi};
                            end
                        end
                        if (!pins_s.sclk && sclk_q && !req_o.rd) begin
                            miso_o <= tx_q[15];
                            tx_q <= {tx_q[14:0], 1'b0};
                        end
                    end
                    default: begin
                        state_q <= pa_loop_pkg::SPI_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: hdl/pa_loop_control_regs.sv
/*
  Loop configuration registers of a four-channel amplifier current controller and the
  amplifier power output control. Assumes alarm and alert inputs come from logic on clk_i
  and that the sleep pins and the serial port pins are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
module pa_loop_control_regs #(
    parameter int STEP_CYCLES = pa_loop_pkg::RAMP_STEP_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic sleep_pin_a_i,
    input wire logic sleep_pin_b_i,
    input wire logic supply_alarm_i,
    input wire logic alert_out_a_i,
    output logic [11:0] monitor_en_o,
    output logic [3:0] soft_limit_en_o,
    output logic [3:0] loop_en_o,
    output logic loop3_fast_ramp_en_o,
    output logic [2:0] loop3_integrator_tc_o,
    output logic [3:0][6:0] ramp_quarters_o,
    output logic ramp_step_tick_o,
    output logic amp_power_output_o
);
    pa_loop_pkg::reg_req_t req;
    logic [15:0] rdata;
    logic [1:0] sleep_s;
    logic [15:0] bg_q;
    logic [15:0] loop_q;
    logic [15:0] pa_q;
    logic [3:0][15:0] ramp_q;
    logic [15:0] frtc_q;
    logic tripped_q;
    logic snooze_a_q;
    logic snooze_b_q;
    logic pin_a_off;
    logic pin_b_off;
    logic alarm_evt;
    logic pa_wr;
    logic [15:0] tick_cnt_q;

    function automatic logic is_ramp(input logic [6:0] addr);
        is_ramp = (addr >= pa_loop_pkg::ADDR_RAMP0) && (addr <= pa_loop_pkg::ADDR_RAMP3);
    endfunction

    function automatic logic [1:0] ramp_idx(input logic [6:0] addr);
        logic [6:0] diff;
        diff = addr - pa_loop_pkg::ADDR_RAMP0;
        ramp_idx = diff[1:0];
    endfunction

    // --------------------------------------------------------------
    // Serial port and pin synchronisers.
    // --------------------------------------------------------------
    spi_reg_port u_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .mosi_i(mosi_i),
        .rdata_i(rdata),
        .req_o(req),
        .miso_o(miso_o),
        .miso_oe_o(miso_oe_o)
    );

    pin_sync #(.W(2)) u_sleep_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({sleep_pin_b_i, sleep_pin_a_i}),
        .q_o(sleep_s)
    );

    // --------------------------------------------------------------
    // Register writes.
    // --------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bg_q <= pa_loop_pkg::RST_BG;
        end else if (req.wr && req.addr == pa_loop_pkg::ADDR_BG) begin
            bg_q <= req.wdata & pa_loop_pkg::MASK_BG;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop_q <= pa_loop_pkg::RST_LOOP;
        end else if (req.wr && req.addr == pa_loop_pkg::ADDR_LOOP) begin
            loop_q <= req.wdata & pa_loop_pkg::MASK_LOOP;
        end
    end

    assign pa_wr = req.wr && req.addr == pa_loop_pkg::ADDR_PA;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_q <= pa_loop_pkg::RST_PA;
        end else if (pa_wr) begin
            pa_q <= req.wdata & pa_loop_pkg::MASK_PA;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_q <= {4{pa_loop_pkg::RST_RAMP}};
        end else if (req.wr && is_ramp(req.addr)) begin
            ramp_q[ramp_idx(req.addr)] <= req.wdata & pa_loop_pkg::MASK_RAMP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frtc_q <= pa_loop_pkg::RST_FRTC;
        end else if (req.wr && req.addr == pa_loop_pkg::ADDR_FRTC) begin
            frtc_q <= req.wdata & pa_loop_pkg::MASK_FRTC;
        end
    end

    // --------------------------------------------------------------
    // Register reads.
    // --------------------------------------------------------------
    always_comb begin
        rdata = 16'h0000;
        if (req.addr == pa_loop_pkg::ADDR_BG) begin
            rdata = bg_q;
        end else if (req.addr == pa_loop_pkg::ADDR_LOOP) begin
            rdata = loop_q;
        end else if (req.addr == pa_loop_pkg::ADDR_PA) begin
            rdata = pa_q;
        end else if (is_ramp(req.addr)) begin
            rdata = ramp_q[ramp_idx(req.addr)];
        end else if (req.addr == pa_loop_pkg::ADDR_FRTC) begin
            rdata = frtc_q;
        end
    end

    // --------------------------------------------------------------
    // Configuration outputs.
    // --------------------------------------------------------------
    assign monitor_en_o = bg_q[11:0];
    assign soft_limit_en_o = loop_q[pa_loop_pkg::LIMIT_LSB +: 4];
    assign loop_en_o = loop_q[pa_loop_pkg::LOOP_LSB +: 4];
    assign loop3_fast_ramp_en_o = frtc_q[pa_loop_pkg::FR3_BIT];
    assign loop3_integrator_tc_o = frtc_q[pa_loop_pkg::TC3_LSB +: 3];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_quarters_o <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                ramp_quarters_o[i] <= pa_loop_pkg::ramp_quarters(ramp_q[i][6:0]);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= 16'h0000;
            ramp_step_tick_o <= 1'b0;
        end else if (tick_cnt_q == 16'(STEP_CYCLES - 1)) begin
            tick_cnt_q <= 16'h0000;
            ramp_step_tick_o <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            ramp_step_tick_o <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Amplifier power output control.
    // --------------------------------------------------------------
    assign alarm_evt = pa_q[pa_loop_pkg::PA_TRIG_BIT] && (supply_alarm_i || alert_out_a_i);
    assign pin_a_off = pa_q[pa_loop_pkg::PA_SLP_A_BIT] && sleep_s[0];
    assign pin_b_off = pa_q[pa_loop_pkg::PA_SLP_B_BIT] && sleep_s[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tripped_q <= 1'b0;
        end else if (alarm_evt) begin
            tripped_q <= 1'b1;
        end else if (pa_wr) begin
            tripped_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snooze_a_q <= 1'b0;
        end else if (pin_a_off && pa_q[pa_loop_pkg::PA_SNZ_A_BIT]) begin
            snooze_a_q <= 1'b1;
        end else if (pa_wr) begin
            snooze_a_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            snooze_b_q <= 1'b0;
        end else if (pin_b_off && pa_q[pa_loop_pkg::PA_SNZ_B_BIT]) begin
            snooze_b_q <= 1'b1;
        end else if (pa_wr) begin
            snooze_b_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_power_output_o <= 1'b0;
        end else begin
            amp_power_output_o <= pa_q[pa_loop_pkg::PA_EN_BIT] && !alarm_evt && !tripped_q
                && !pin_a_off && !pin_b_off && !snooze_a_q && !snooze_b_q;
        end
    end

    // --------------------------------------------------------------
    // Checks.
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence pa_write_s;
        req.wr && req.addr == pa_loop_pkg::ADDR_PA;
    endsequence

    sequence alarm_s;
        pa_q[pa_loop_pkg::PA_TRIG_BIT] && (supply_alarm_i || alert_out_a_i);
    endsequence

    chk_bg_write: assert property (req.wr && req.addr == pa_loop_pkg::ADDR_BG |=>
        monitor_en_o == $past(req.wdata[11:0]) && bg_q[15:12] == 4'h0)
        else $error("background enable write not taken");

    chk_limit_write: assert property (req.wr && req.addr == pa_loop_pkg::ADDR_LOOP |=>
        soft_limit_en_o == $past(req.wdata[11:8]))
        else $error("soft limit enables not taken");

    chk_loop_write: assert property (req.wr && req.addr == pa_loop_pkg::ADDR_LOOP |=>
        loop_en_o == $past(req.wdata[3:0]) && loop_q[7:4] == 4'h0)
        else $error("loop enables not taken");

    chk_pa_off: assert property (!pa_q[pa_loop_pkg::PA_EN_BIT] |=> !amp_power_output_o)
        else $error("amplifier output on while disabled");

    chk_amp_power_output: assert property (pa_q[pa_loop_pkg::PA_EN_BIT] && !alarm_evt && !tripped_q && !pin_a_off
        && !pin_b_off && !snooze_a_q && !snooze_b_q |=> amp_power_output_o)
        else $error("amplifier output off while enabled");

    chk_alarm_trip: assert property (alarm_s ##1 !pa_wr |->
        (!amp_power_output_o && tripped_q) ##1 tripped_q)
        else $error("alarm did not hold the amplifier off");

    chk_trip_clear: assert property (pa_write_s ##0 !alarm_evt |=> !tripped_q)
        else $error("control write did not clear the alarm trip");

    chk_snooze_b: assert property (pin_b_off && pa_q[pa_loop_pkg::PA_SNZ_B_BIT] |=> snooze_b_q)
        else $error("second sleep pin did not snooze");

    chk_snooze_a: assert property (pin_a_off && pa_q[pa_loop_pkg::PA_SNZ_A_BIT] |=> snooze_a_q
        ##1 !amp_power_output_o)
        else $error("first sleep pin did not snooze");

    chk_pin_b_ctl: assert property (pin_b_off |=> !amp_power_output_o)
        else $error("second sleep pin did not turn the output off");

    chk_pin_a_ctl: assert property (pin_a_off |=> !amp_power_output_o)
        else $error("first sleep pin did not turn the output off");

    chk_ramp_zero: assert property (ramp_q[0][6:0] == 7'h00 |=> ramp_quarters_o[0] == 7'h00)
        else $error("zero ramp code did not disable ramping");

    chk_ramp_min: assert property (ramp_q[3][6:0] != 7'h00 && ramp_q[3][6:0] <= 7'h10
        |=> ramp_quarters_o[3] == 7'h10)
        else $error("short ramp code not held at the minimum");

    chk_ramp_step: assert property (ramp_q[2][6:0] > 7'h10 |=> ramp_quarters_o[2] == $past(ramp_q[2][6:0]))
        else $error("long ramp code not in quarter steps");

    chk_ramp_write: assert property (req.wr && req.addr == pa_loop_pkg::ADDR_RAMP3 |=>
        ramp_q[3] == {9'h000, $past(req.wdata[6:0])})
        else $error("ramp time write not taken");

    chk_tick_gap: assert property (ramp_step_tick_o |=> !ramp_step_tick_o)
        else $error("ramp step tick longer than one cycle");

    chk_frtc_reset: assert property ($fell(rst_i) |-> loop3_fast_ramp_en_o
        && loop3_integrator_tc_o == 3'h3)
        else $error("fast ramp register reset value wrong");

    chk_frtc_write: assert property (req.wr && req.addr == pa_loop_pkg::ADDR_FRTC |=>
        loop3_integrator_tc_o == $past(req.wdata[14:12]) && frtc_q[11:0] == 12'h000)
        else $error("integrator time constant write not taken");

    chk_reserved_read: assert property (req.addr == pa_loop_pkg::ADDR_PA |->
        (rdata & ~pa_loop_pkg::MASK_PA) == 16'h0000)
        else $error("reserved bits read as nonzero");

endmodule
`default_nettype wire

// file: testbench/pa_loop_control_regs_bench.sv
/*
  Self-checking bench for the loop configuration registers and amplifier output control.
  Assumes the serial port timing and the output delays given for the design.
*/
`timescale 1ns/100ps
`default_nettype none
module pa_loop_control_regs_bench;
    // ----------------------------------------
    // Stimulus and design.
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sclk_i = 1'b0;
    logic cs_n_i = 1'b1;
    logic mosi_i = 1'b0;
    logic sleep_pin_a_i = 1'b0;
    logic sleep_pin_b_i = 1'b0;
    logic supply_alarm_i = 1'b0;
    logic alert_out_a_i = 1'b0;
    logic miso_o, miso_oe_o, loop3_fast_ramp_en_o, ramp_step_tick_o, amp_power_output_o;
    logic [11:0] monitor_en_o;
    logic [3:0] soft_limit_en_o, loop_en_o;
    logic [2:0] loop3_integrator_tc_o;
    logic [3:0][6:0] ramp_quarters_o;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #10 clk_i = ~clk_i;

    pa_loop_control_regs #(.STEP_CYCLES(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
        .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .sleep_pin_a_i(sleep_pin_a_i), .sleep_pin_b_i(sleep_pin_b_i), .supply_alarm_i(supply_alarm_i),
        .alert_out_a_i(alert_out_a_i), .monitor_en_o(monitor_en_o), .soft_limit_en_o(soft_limit_en_o),
        .loop_en_o(loop_en_o), .loop3_fast_ramp_en_o(loop3_fast_ramp_en_o),
        .loop3_integrator_tc_o(loop3_integrator_tc_o), .ramp_quarters_o(ramp_quarters_o),
        .ramp_step_tick_o(ramp_step_tick_o), .amp_power_output_o(amp_power_output_o));

    // ----------------------------------------
    // Shared tasks.
    // ----------------------------------------
    task automatic summarize();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // One 24-bit frame; read data is sampled just before each of the 16 data-bit rising serial edges.
    task automatic frame(input logic rd, input logic [6:0] a, input logic [15:0] wd, output logic [15:0] rv);
        logic [23:0] bits;
        bits = {rd, a, wd};
        rv = 16'h0000;
        cs_n_i = 1'b0;
        for (int b = 23; b >= 0; b--) begin
            mosi_i = bits[b];
            wait_clk(5);
            if (b < 16) rv[b] = miso_o;
            if (b == 0) check(32'(miso_oe_o), 32'h00000001);
            sclk_i = 1'b1;
            wait_clk(5);
            sclk_i = 1'b0;
        end
        wait_clk(5);
        cs_n_i = 1'b1;
        wait_clk(8);
        check(32'(miso_oe_o), 32'h00000000);
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] r;
        frame(1'b0, a, d, r);
    endtask

    task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
        logic [15:0] r;
        frame(1'b1, a, 16'h0000, r);
        check(32'(r), 32'(e));
    endtask

    // ----------------------------------------
    // Scenarios.
    // ----------------------------------------
    task automatic reset_values();
        rdchk(7'h23, 16'h0000);
        rdchk(7'h28, 16'h0000);
        rdchk(7'h29, 16'h0130);
        for (int i = 0; i < 4; i++) rdchk(7'h2A + 7'(i), 16'h0000);
        rdchk(7'h2E, 16'hB000);
        check(32'({loop3_fast_ramp_en_o, loop3_integrator_tc_o, amp_power_output_o}), 32'h00000016);
    endtask

    task automatic write_masks();
        logic [6:0] adr [8] = '{7'h23, 7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E};
        logic [15:0] msk [8] = '{16'h0FFF, 16'h0F0F, 16'h0333, 16'h007F, 16'h007F, 16'h007F, 16'h007F, 16'hF000};
        logic [15:0] pat [2] = '{16'hFFFF, 16'h5A5A};
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) wr(adr[i], pat[p]);
            for (int i = 0; i < 8; i++) rdchk(adr[i], pat[p] & msk[i]);
            check(32'({monitor_en_o, soft_limit_en_o, loop_en_o}),
                32'({pat[p][11:0], pat[p][11:8], pat[p][3:0]}));
            check(32'({loop3_fast_ramp_en_o, loop3_integrator_tc_o}), 32'(pat[p][15:12]));
        end
        wr(7'h30, 16'hFFFF);
        rdchk(7'h30, 16'h0000);
    endtask

    task automatic ramp_codes();
        logic [6:0] code [5] = '{7'h00, 7'h01, 7'h10, 7'h11, 7'h7F};
        logic [6:0] qrt [5] = '{7'h00, 7'h10, 7'h10, 7'h11, 7'h7F};
        int n;
        for (int k = 0; k < 5; k++) begin
            wr(7'h2A, 16'(code[k]));
            wr(7'h2D, 16'(code[k]) | 16'hFF80);
            check(32'(ramp_quarters_o), 32'({qrt[k], 7'h5A, 7'h5A, qrt[k]}));
        end
        n = 0;
        repeat (80) begin
            @(negedge clk_i);
            n += int'(ramp_step_tick_o === 1'b1);
        end
        check(32'(n), 32'h0000000A);
    endtask

    task automatic tc_codes();
        for (int c = 1; c < 8; c++) begin
            wr(7'h2E, {c[0], 3'(c), 12'hFFF});
            check(32'({loop3_fast_ramp_en_o, loop3_integrator_tc_o}), 32'({c[0], 3'(c)}));
            rdchk(7'h2E, {c[0], 3'(c), 12'h000});
        end
    endtask

    task automatic amp_control();
        logic [15:0] val [5] = '{16'h0201, 16'h0211, 16'h0202, 16'h0222, 16'h0230};
        logic [4:0] exp_on [5] = '{5'h01, 5'h00, 5'h01, 5'h00, 5'h03};
        wr(7'h29, 16'h0200);
        supply_alarm_i = 1'b1;
        alert_out_a_i = 1'b1;
        wait_clk(6);
        check(32'(amp_power_output_o), 32'h00000001);
        supply_alarm_i = 1'b0;
        alert_out_a_i = 1'b0;
        for (int s = 0; s < 2; s++) begin
            wr(7'h29, 16'h0300);
            check(32'(amp_power_output_o), 32'h00000001);
            if (s == 0) supply_alarm_i = 1'b1;
            else alert_out_a_i = 1'b1;
            wait_clk(1);
            supply_alarm_i = 1'b0;
            alert_out_a_i = 1'b0;
            wait_clk(5);
            check(32'(amp_power_output_o), 32'h00000000);
        end
        for (int k = 0; k < 5; k++) begin
            wr(7'h29, val[k]);
            if (val[k][1]) sleep_pin_b_i = 1'b1;
            else sleep_pin_a_i = 1'b1;
            wait_clk(6);
            check(32'(amp_power_output_o), 32'(exp_on[k][1]));
            sleep_pin_a_i = 1'b0;
            sleep_pin_b_i = 1'b0;
            wait_clk(6);
            check(32'(amp_power_output_o), 32'(exp_on[k][0]));
        end
        wr(7'h29, 16'h0000);
        check(32'(amp_power_output_o), 32'h00000000);
    endtask

    initial begin
        wait_clk(16);
        rst_i = 1'b0;
        wait_clk(1);
        reset_values();
        write_masks();
        ramp_codes();
        tc_codes();
        amp_control();
        summarize();
    end
endmodule
`default_nettype wire
